// >>> pkg/smc_regs.vh
// Register map, field positions and decode constants of the system memory controller
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
`define SMC_OFF_REMAP 8'h00
`define SMC_OFF_STATUS 8'h04
`define SMC_OFF_ADDR 8'h08
`define SMC_BIT_TOGGLE 0
`define SMC_REG_RESET 32'h00000000
`define SMC_REGION_INT 4'h0
`define SMC_REGION_PERIPH 4'hf
`define SMC_REGION_BITS 31:28
`define SMC_SLOT_BITS 27:20
`define SMC_ST_UNDEF 0
`define SMC_ST_MISAL 1
`define SMC_ST_SIZE 9:8
`define SMC_ST_TYPE 11:10
`define SMC_ST_LAST 18:16
`define SMC_ST_SAVED 26:24
`define SMC_SLOT_ALIAS 8'h00
`define SMC_SLOT_FLASH 8'h01
`define SMC_SLOT_SRAM 8'h02
`define SMC_SLOT_ROM 8'h03
`define SMC_SIZE_BYTE 2'h0
`define SMC_SIZE_HALF 2'h1
`define SMC_SIZE_WORD 2'h2
`define SMC_TYPE_READ 2'h0
`define SMC_TYPE_WRITE 2'h1
`define SMC_TYPE_FETCH 2'h2
`define SMC_TGT_NONE 3'h0
`define SMC_TGT_FLASH 3'h1
`define SMC_TGT_SRAM 3'h2
`define SMC_TGT_ROM 3'h3
`define SMC_TGT_PERIPH 3'h4
`define SMC_MST_ETH 2'h0
`define SMC_MST_DMA 2'h1
`define SMC_MST_CPU 2'h2
`define SMC_MST_NONE 2'h3
`endif

// >>> hdl/smc_arbiter.v
// Fixed priority arbiter for the three bus masters
`timescale 1ns/10ps
module smc_arbiter (
  // Clock and reset
  input wire sysClk,
  input wire reset,
  // Requests and transfer boundary
  input wire [2:0] request,
  input wire transferDone,
  // Grant
  output reg [1:0] owner,
  output reg ownerValid
);
`include "smc_regs.vh"

  reg [1:0] next_owner;

  // Priority pick: ethernet, then dma, then cpu
  always @* begin
    next_owner = `SMC_MST_NONE;
    // RULE2: fixed priority order
    if (request[0]) begin
      next_owner = `SMC_MST_ETH;
    end else if (request[1]) begin
      next_owner = `SMC_MST_DMA;
    end else if (request[2]) begin
      next_owner = `SMC_MST_CPU;
    end
  end

  // Grant held until transfer boundary
  always @(posedge sysClk) begin
    if (reset) begin
      owner <= `SMC_MST_NONE;
      ownerValid <= 1'b0;
    // RULE24: re-arbitrate at boundary
    end else if (transferDone) begin
      // Release in the done cycle so a finished master is not granted again
      owner <= `SMC_MST_NONE;
      ownerValid <= 1'b0;
    end else if (!ownerValid) begin
      owner <= next_owner;
      ownerValid <= |request;
    end
  end
endmodule // smc_arbiter

// >>> hdl/smc_decoder.v
// Address decoder and misalignment detector
`timescale 1ns/10ps
module smc_decoder (
  // Access
  input wire [31:0] addr,
  input wire [1:0] size,
  input wire [1:0] accType,
  input wire [1:0] master,
  input wire remapped,
  // Result
  output reg [2:0] target,
  output reg undefinedHit,
  output reg misaligned
);
`include "smc_regs.vh"

  // Region and slot decode
  always @* begin
    target = `SMC_TGT_NONE;
    undefinedHit = 1'b0;
    // RULE3: region by bits 31:28
    if (addr[`SMC_REGION_BITS] == `SMC_REGION_INT) begin
      // RULE5: slot by bits 27:20
      case (addr[`SMC_SLOT_BITS])
        // RULE9: slot zero alias
        `SMC_SLOT_ALIAS: target = remapped ? `SMC_TGT_SRAM : `SMC_TGT_FLASH;
        // RULE7: fixed slot assignment
        `SMC_SLOT_FLASH: target = `SMC_TGT_FLASH;
        `SMC_SLOT_SRAM: target = `SMC_TGT_SRAM;
        `SMC_SLOT_ROM: target = `SMC_TGT_ROM;
        // RULE8: internal hole aborts
        default: undefinedHit = 1'b1;
      endcase
    // RULE25: topmost region peripherals
    end else if (addr[`SMC_REGION_BITS] == `SMC_REGION_PERIPH) begin
      target = `SMC_TGT_PERIPH;
    end else begin
      // RULE4: undefined region aborts
      undefinedHit = 1'b1;
    end
  end

  // Alignment check, cpu fetch exempt
  always @* begin
    misaligned = 1'b0;
    // RULE19: skip cpu fetches
    if (!(master == `SMC_MST_CPU && accType == `SMC_TYPE_FETCH)) begin
      // RULE18: word and half alignment
      if (size == `SMC_SIZE_WORD) begin
        misaligned = |addr[1:0];
      end else if (size == `SMC_SIZE_HALF) begin
        misaligned = addr[0];
      end
    end
  end
endmodule // smc_decoder

// >>> hdl/smc_controller.v
// System bus memory controller: arbitration, decode, remap, abort status, APB registers
// Operation
// RULE1: Only little-endian accesses; masters issue little-endian transfers.
// RULE2: Fixed grant priority: ethernet, then dma, then processor.
// RULE3: Bits 31:28 pick internal, peripheral, or one of fourteen undefined regions.
// RULE4: Accesses to undefined 256-Mbyte regions are aborted.
// RULE5: Eight more bits pick 1-Mbyte slots inside internal region.
// RULE6: Each memory answers across its whole slot, mirrored.
// RULE7: Slot 1 flash, 2 SRAM, 3 ROM; slot 4 upward aborts.
// RULE8: Undefined internal addresses abort to the issuing master.
// RULE9: Slot 0 aliases flash, or SRAM when remapped.
// RULE10: Writing one to toggle bit inverts remap; zero does nothing.
// RULE11: Remap cleared at reset; two toggles restore reset map.
// RULE12: Abort indication goes to all masters.
// RULE13: Only the processor acts on abort, while accessing.
// RULE14: Full 32-bit address of each aborted access is captured.
// RULE15: Size, type, cause and source of each abort recorded.
// RULE16: Per-master saved flag for aborts not in last-source bits.
// RULE17: Processor data abort captures the data address.
// RULE18: Misaligned word or half-word accesses abort and are cancelled.
// RULE19: Processor instruction fetches skip alignment check.
// RULE20: Size code 0 byte, 1 half, 2 word.
// RULE21: Type code 0 read, 1 write, 2 fetch.
// RULE22: Status bit layout 0,1,9:8,11:10,18:16,26:24.
// RULE23: New abort overwrites fields; status read clears saved flags.
// RULE24: Arbiter switches only at transfer boundaries.
// RULE25: Peripheral region is 0xF0000000 upward, forwarded to peripheral bus.
`timescale 1ns/10ps
module smc_controller #(
  parameter FLASH_AW = 18,
  parameter SRAM_AW = 16,
  parameter ROM_AW = 14
) (
  // Clock and reset
  input wire sysClk,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Ethernet master
  input wire ethReq,
  input wire [31:0] ethAddr,
  input wire [1:0] ethSize,
  input wire ethWrite,
  input wire [31:0] ethWdata,
  // DMA master
  input wire dmaReq,
  input wire [31:0] dmaAddr,
  input wire [1:0] dmaSize,
  input wire dmaWrite,
  input wire [31:0] dmaWdata,
  // Processor master
  input wire cpuReq,
  input wire [31:0] cpuAddr,
  input wire [1:0] cpuSize,
  input wire [1:0] cpuType,
  input wire [31:0] cpuWdata,
  // Answers to the masters
  output reg [2:0] grant,
  output reg busDone,
  output reg busAbort,
  output reg [31:0] busRdata,
  // Shared memory and peripheral port
  output reg flashSel,
  output reg sramSel,
  output reg romSel,
  output reg periphSel,
  output reg [31:0] memAddr,
  output reg [1:0] memSize,
  output reg memWrite,
  output reg [31:0] memWdata,
  input wire [31:0] memRdata,
  input wire memReady,
  // Remap state
  output reg remapped
);
`include "smc_regs.vh"

  // Internal state
  reg busy;
  reg [31:0] abortAddr;
  reg undefinedFlag;
  reg misalignedFlag;
  reg [1:0] abortSize;
  reg [1:0] abortType;
  reg [2:0] lastSrc;
  reg [2:0] savedSrc;
  reg [1:0] selMaster;
  reg [31:0] selAddr;
  reg [1:0] selSize;
  reg [1:0] selType;
  reg [31:0] selWdata;
  reg [31:0] regRead;
  reg [31:0] statusWord;
  reg lastFresh;
  wire [2:0] abortOneHot;
  wire statusRead;
  wire [2:0] unreadPrev;
  wire [1:0] owner;
  wire ownerValid;
  wire [2:0] target;
  wire undefinedHit;
  wire misaligned;
  wire apbAccess;
  wire transferDone;
  wire abortNow;

  // One-hot of a master code
  function [2:0] master_bit;
    input [1:0] code;
    begin
      case (code)
        `SMC_MST_ETH: master_bit = 3'h1;
        `SMC_MST_DMA: master_bit = 3'h2;
        `SMC_MST_CPU: master_bit = 3'h4;
        default: master_bit = 3'h0;
      endcase
    end
  endfunction

  // Mirror address within a memory of given width
  function [31:0] mirror;
    input [31:0] a;
    input integer aw;
    begin
      mirror = a & ((32'h1 << aw) - 32'h1);
    end
  endfunction

  smc_arbiter u_arbiter (
    .sysClk(sysClk),
    .reset(reset),
    .request({cpuReq, dmaReq, ethReq}),
    .transferDone(transferDone),
    .owner(owner),
    .ownerValid(ownerValid)
  );

  // Select the granted master's request
  always @* begin
    selMaster = owner;
    selAddr = cpuAddr;
    selSize = cpuSize;
    selType = cpuType;
    selWdata = cpuWdata;
    case (owner)
      `SMC_MST_ETH: begin
        selAddr = ethAddr;
        selSize = ethSize;
        selType = ethWrite ? `SMC_TYPE_WRITE : `SMC_TYPE_READ;
        selWdata = ethWdata;
      end
      `SMC_MST_DMA: begin
        selAddr = dmaAddr;
        selSize = dmaSize;
        selType = dmaWrite ? `SMC_TYPE_WRITE : `SMC_TYPE_READ;
        selWdata = dmaWdata;
      end
      default: begin
        selAddr = cpuAddr;
      end
    endcase
  end

  smc_decoder u_decoder (
    .addr(selAddr),
    .size(selSize),
    .accType(selType),
    .master(selMaster),
    .remapped(remapped),
    .target(target),
    .undefinedHit(undefinedHit),
    .misaligned(misaligned)
  );

  // An access aborts on decode miss or misalignment; none starts in the done cycle
  assign abortNow = ownerValid && !busy && !busDone && (undefinedHit || misaligned);
  // Boundary is the done cycle, the master drops its request only at the end of it
  assign transferDone = busDone;
  assign abortOneHot = master_bit(selMaster);

  // Bus sequencing toward memories and answers
  always @(posedge sysClk) begin
    if (reset) begin
      busy <= 1'b0;
      grant <= 3'h0;
      busDone <= 1'b0;
      busAbort <= 1'b0;
      busRdata <= `SMC_REG_RESET;
      flashSel <= 1'b0;
      sramSel <= 1'b0;
      romSel <= 1'b0;
      periphSel <= 1'b0;
      memAddr <= `SMC_REG_RESET;
      memSize <= `SMC_SIZE_BYTE;
      memWrite <= 1'b0;
      memWdata <= `SMC_REG_RESET;
    end else begin
      busDone <= 1'b0;
      busAbort <= 1'b0;
      grant <= (ownerValid && !busDone) ? master_bit(owner) : 3'h0;
      if (busy) begin
        if (memReady) begin
          busy <= 1'b0;
          busDone <= 1'b1;
          busRdata <= memRdata;
          flashSel <= 1'b0;
          sramSel <= 1'b0;
          romSel <= 1'b0;
          periphSel <= 1'b0;
        end
      end else if (abortNow) begin
        // RULE12: abort to all masters
        // RULE18: access cancelled
        busAbort <= 1'b1;
        busDone <= 1'b1;
      end else if (ownerValid && !busDone) begin
        busy <= 1'b1;
        flashSel <= target == `SMC_TGT_FLASH;
        sramSel <= target == `SMC_TGT_SRAM;
        romSel <= target == `SMC_TGT_ROM;
        periphSel <= target == `SMC_TGT_PERIPH;
        // RULE6: mirror within slot
        case (target)
          `SMC_TGT_FLASH: memAddr <= mirror(selAddr, FLASH_AW);
          `SMC_TGT_SRAM: memAddr <= mirror(selAddr, SRAM_AW);
          `SMC_TGT_ROM: memAddr <= mirror(selAddr, ROM_AW);
          default: memAddr <= selAddr;
        endcase
        memSize <= selSize;
        memWrite <= selType == `SMC_TYPE_WRITE;
        // RULE1: little-endian pass-through
        memWdata <= selWdata;
      end
    end
  end

  assign apbAccess = psel && penable;
  // Status read at the access edge; previous abort still unread
  assign statusRead = apbAccess && !pwrite && paddr[7:0] == `SMC_OFF_STATUS;
  assign unreadPrev = (lastFresh ? lastSrc : 3'h0) & ~abortOneHot;

  // Remap toggle register
  always @(posedge sysClk) begin
    if (reset) begin
      // RULE11: cleared at reset
      remapped <= 1'b0;
    // RULE10: one toggles remap
    end else if (apbAccess && pwrite && paddr[7:0] == `SMC_OFF_REMAP
        && pwdata[`SMC_BIT_TOGGLE]) begin
      remapped <= ~remapped;
    end
  end

  // Abort status capture
  always @(posedge sysClk) begin
    if (reset) begin
      abortAddr <= `SMC_REG_RESET;
      undefinedFlag <= 1'b0;
      misalignedFlag <= 1'b0;
      abortSize <= `SMC_SIZE_BYTE;
      abortType <= `SMC_TYPE_READ;
      lastSrc <= 3'h0;
      savedSrc <= 3'h0;
      lastFresh <= 1'b0;
    end else begin
      if (abortNow) begin
        // RULE14: full address captured
        // RULE17: data address stored
        abortAddr <= selAddr;
        // RULE15: cause, size, type, source
        // RULE23: fields overwritten
        undefinedFlag <= undefinedHit;
        misalignedFlag <= misaligned;
        // RULE20: size code
        abortSize <= selSize;
        // RULE21: type code
        abortType <= selType;
        lastSrc <= abortOneHot;
      end
      // Last abort unread until status read, set beats clear
      if (abortNow) begin
        lastFresh <= 1'b1;
      end else if (statusRead) begin
        lastFresh <= 1'b0;
      end
      // RULE16: saved flags, set beats clear
      if (statusRead) begin
        savedSrc <= abortNow ? unreadPrev : 3'h0;
      end else if (abortNow) begin
        savedSrc <= savedSrc | unreadPrev;
      end
    end
  end

  // Status word layout
  always @* begin
    statusWord = `SMC_REG_RESET;
    // RULE22: field positions
    statusWord[`SMC_ST_UNDEF] = undefinedFlag;
    statusWord[`SMC_ST_MISAL] = misalignedFlag;
    statusWord[`SMC_ST_SIZE] = abortSize;
    statusWord[`SMC_ST_TYPE] = abortType;
    statusWord[`SMC_ST_LAST] = lastSrc;
    statusWord[`SMC_ST_SAVED] = savedSrc;
    case (paddr[7:0])
      `SMC_OFF_STATUS: regRead = statusWord;
      `SMC_OFF_ADDR: regRead = abortAddr;
      default: regRead = `SMC_REG_RESET;
    endcase
  end

  // APB answer: one access cycle, no wait
  always @(posedge sysClk) begin
    if (reset) begin
      prdata <= `SMC_REG_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= pwrite ? `SMC_REG_RESET : regRead;
        pslverr <= !(paddr[7:0] == `SMC_OFF_REMAP || paddr[7:0] == `SMC_OFF_STATUS
            || paddr[7:0] == `SMC_OFF_ADDR);
      end
    end
  end
endmodule // smc_controller

// >>> sim/smc_controller_sva.sv
// Port checker for the system memory controller
`timescale 1ns/10ps
module smc_controller_sva #(
  parameter FLASH_AW = 18,
  parameter SRAM_AW = 16,
  parameter ROM_AW = 14
) (
  // Clock and reset
  input wire sysClk,
  input wire reset,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Master answers and memory port
  input wire [2:0] grant,
  input wire busDone,
  input wire busAbort,
  input wire flashSel,
  input wire sramSel,
  input wire romSel,
  input wire periphSel,
  input wire [31:0] memAddr,
  input wire remapped
);
  // Completed write of a one to the toggle bit
  wire flipWr = psel && penable && pready && pwrite && paddr[7:0] == 8'h00 && pwdata[0];
  wire anySel = flashSel || sramSel || romSel || periphSel;
  default clocking cb @(posedge sysClk);
  endclocking
  default disable iff (reset);
  grant_hold_a: assert property (
    grant != 3'h0 && !busDone |=> grant == $past(grant)) else $error("grant moved mid transfer");
  abort_done_a: assert property (
    busAbort |-> busDone) else $error("abort without done");
  abort_nosel_a: assert property (
    busAbort |-> !anySel && !$past(anySel)) else $error("aborted access reached memory");
  sel_onehot_a: assert property (
    $onehot0({flashSel, sramSel, romSel, periphSel})) else $error("several selects");
  periph_addr_a: assert property (
    periphSel |-> memAddr[31:28] == 4'hf) else $error("peripheral select outside top area");
  mirror_range_a: assert property (
    (!flashSel || memAddr >> FLASH_AW == 0) && (!sramSel || memAddr >> SRAM_AW == 0)
    && (!romSel || memAddr >> ROM_AW == 0)) else $error("memory address not folded");
  remap_flip_a: assert property (
    flipWr |=> remapped != $past(remapped)) else $error("remap did not invert");
  remap_keep_a: assert property (
    !flipWr |=> $stable(remapped)) else $error("remap changed without toggle");
endmodule // smc_controller_sva
bind smc_controller smc_controller_sva #(.FLASH_AW(FLASH_AW), .SRAM_AW(SRAM_AW),
  .ROM_AW(ROM_AW)) chk (.sysClk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .grant, .busDone, .busAbort, .flashSel, .sramSel, .romSel, .periphSel, .memAddr, .remapped);

// >>> sim/smc_mem_model.sv
// Memory and peripheral responder with adjustable latency
`timescale 1ns/10ps
module smc_mem_model (
  // Clock and reset
  input wire sysClk,
  input wire reset,
  // Access from the controller
  input wire anySel,
  input wire [31:0] memAddr,
  input wire [3:0] latency,
  // Answer
  output reg [31:0] memRdata,
  output reg memReady
);
  reg [3:0] count;
  // little-endian words
  // Ready latency plus one cycles after select, data turns over when not ready
  always @(posedge sysClk) begin
    if (reset || !anySel || memReady) begin
      count <= 4'h0;
      memReady <= 1'h0;
    end else begin
      count <= count + 4'h1;
      memReady <= (count == latency);
    end
    if (reset)
      memRdata <= 32'h0;
    else if (anySel && !memReady && count == latency)
      memRdata <= memAddr ^ 32'h5a5a_0000;
    else
      memRdata <= ~memRdata;
  end
endmodule // smc_mem_model

// >>> sim/smc_controller_bench.sv
// Self-checking bench for the system memory controller
`timescale 1ns/10ps
`define CK(n, e, a) begin checksDone++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module smc_controller_bench;
  localparam FAW = 18;
  localparam SAW = 16;
  localparam RAW = 14;
  logic sysClk, reset, psel, penable, pwrite, pready, pslverr, busDone, busAbort, memReady;
  logic flashSel, sramSel, romSel, periphSel, remapped, memWrite;
  logic [31:0] paddr, pwdata, prdata, mAddr, busRdata, memAddr, memRdata, memWdata;
  logic [2:0] req, grant;
  logic [1:0] mSize, mType, memSize;
  logic [3:0] latency;
  int miscompares = 0;
  int checksDone = 0;
  wire anySel = flashSel | sramSel | romSel | periphSel;
  smc_controller #(.FLASH_AW(FAW), .SRAM_AW(SAW), .ROM_AW(RAW)) dut (.sysClk, .reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ethReq(req[0]), .ethAddr(mAddr), .ethSize(mSize), .ethWrite(mType[0]), .ethWdata(mAddr),
    .dmaReq(req[1]), .dmaAddr(mAddr), .dmaSize(mSize), .dmaWrite(mType[0]), .dmaWdata(mAddr),
    .cpuReq(req[2]), .cpuAddr(mAddr), .cpuSize(mSize), .cpuType(mType), .cpuWdata(mAddr),
    .grant, .busDone, .busAbort, .busRdata, .flashSel, .sramSel, .romSel, .periphSel,
    .memAddr, .memSize, .memWrite, .memWdata, .memRdata, .memReady, .remapped);
  smc_mem_model mem (.sysClk, .reset, .anySel, .memAddr, .latency, .memRdata, .memReady);
  // Clock
  initial begin
    sysClk = 1'h0;
    forever #4 sysClk = ~sysClk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic timeout;
    miscompares++;
    $display("mismatch wait exp answer got none");
    tally_and_finish;
  endtask
  // One register bus transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    int n;
    @(posedge sysClk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge sysClk);
      if (pready === 1'h1) break;
    end
    if (n == 20) timeout;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One master access; records selects and folded address
  task automatic mreq(input int m, input logic [31:0] a, input logic [1:0] sz, ty,
      output logic ab, output logic [3:0] sl, output logic [31:0] ma, rd);
    int n;
    sl = 4'h0;
    ma = 32'h0;
    @(posedge sysClk);
    mAddr <= a;
    mSize <= sz;
    mType <= ty;
    req <= 3'(1 << m);
    for (n = 0; n < 40; n++) begin
      @(posedge sysClk);
      if ({flashSel, sramSel, romSel, periphSel} != 4'h0) begin
        sl = sl | {flashSel, sramSel, romSel, periphSel};
        ma = memAddr;
        `CK("mem size", sz, memSize)
        `CK("mem write", ty == 2'h1, memWrite)
        `CK("mem wdata", a, memWdata)
      end
      if (busDone === 1'h1) break;
    end
    if (n == 40) timeout;
    ab = busAbort;
    rd = busRdata;
    req <= 3'h0;
  endtask
  task automatic t_regs;
    logic [31:0] rd;
    logic er;
    `CK("remap at reset", 1'h0, remapped)
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0, rd, er);
      `CK("reset value", 32'h0, rd)
    end
    apb(1'h1, 8'h08, 32'hffff_ffff, rd, er);
    apb(1'h0, 8'h08, 32'h0, rd, er);
    `CK("read only", 32'h0, rd)
    apb(1'h0, 8'h0c, 32'h0, rd, er);
    `CK("unmapped", 1'h1, er)
    $display("done registers");
  endtask
  task automatic t_decode;
    logic [31:0] fm = (32'h1 << FAW) - 1;
    logic [31:0] ad [5] = '{32'h0010_0000, 32'h0024_0004, 32'h0037_fffc, 32'hf000_0010, 32'h8};
    logic [31:0] mk [5] = '{fm, (32'h1 << SAW) - 1, (32'h1 << RAW) - 1, 32'hffff_ffff, fm};
    logic [3:0] es [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8};
    logic [31:0] ma, rd;
    logic [3:0] sl;
    logic ab;
    for (int i = 0; i < 5; i++) begin
      latency <= 4'(i);
      mreq(i % 3, ad[i], 2'h2, 2'(i % 2), ab, sl, ma, rd);
      `CK("select", es[i], sl)
      `CK("memory address", ad[i] & mk[i], ma)
      `CK("read data", (ad[i] & mk[i]) ^ 32'h5a5a_0000, rd)
    end
    $display("done decode");
  endtask
  task automatic t_abort;
    int ms [5] = '{2, 0, 1, 2, 2};
    logic [31:0] ad [5] = '{32'h1000_0000, 32'h0010_0002, 32'h0020_0001, 32'h0040_0000,
      32'h2000_0000};
    logic [1:0] sz [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h2};
    logic [1:0] ty [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
    logic [31:0] st [5] = '{32'h0004_0201, 32'h0, 32'h0102_0102, 32'h0004_0401, 32'h0004_0a01};
    logic [31:0] ma, rd;
    logic [3:0] sl;
    logic ab, er;
    for (int i = 0; i < 5; i++) begin
      mreq(ms[i], ad[i], sz[i], ty[i], ab, sl, ma, rd);
      `CK("abort", 1'h1, ab)
      `CK("no select", 4'h0, sl)
      if (i != 1) begin
        apb(1'h0, 8'h04, 32'h0, rd, er);
        `CK("status", st[i], rd)
        apb(1'h0, 8'h04, 32'h0, rd, er);
        `CK("status reread", st[i] & 32'h00ff_ffff, rd)
        apb(1'h0, 8'h08, 32'h0, rd, er);
        `CK("abort address", ad[i], rd)
      end
    end
    mreq(2, 32'h0010_0002, 2'h2, 2'h2, ab, sl, ma, rd);
    `CK("fetch unchecked", 1'h0, ab)
    `CK("fetch select", 4'h8, sl)
    $display("done aborts");
  endtask
  task automatic t_remap;
    logic [31:0] wd [3] = '{32'h1, 32'h0, 32'h1};
    logic er3 [3] = '{1'h1, 1'h1, 1'h0};
    logic [3:0] es [3] = '{4'h4, 4'h4, 4'h8};
    logic [31:0] ma, rd;
    logic [3:0] sl;
    logic ab, er;
    for (int k = 0; k < 3; k++) begin
      apb(1'h1, 8'h00, wd[k], rd, er);
      @(negedge sysClk);
      `CK("remap state", er3[k], remapped)
      mreq(2, 32'h0000_0010, 2'h2, 2'h0, ab, sl, ma, rd);
      `CK("slot zero", es[k], sl)
    end
    $display("done remap");
  endtask
  task automatic t_prio;
    int n;
    int k;
    k = 0;
    latency <= 4'h3;
    @(posedge sysClk);
    mAddr <= 32'h0020_0000;
    mSize <= 2'h2;
    mType <= 2'h0;
    req <= 3'h7;
    for (n = 0; n < 200 && k < 3; n++) begin
      @(posedge sysClk);
      if (busDone === 1'h1) begin
        `CK("grant order", 3'(1 << k), grant)
        req <= req & ~grant;
        k++;
      end
    end
    if (k < 3) timeout;
    $display("done priority");
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req, mAddr, mSize, mType, latency} = '0;
    reset = 1'h1;
    repeat (5) @(posedge sysClk);
    reset <= 1'h0;
    t_regs;
    t_decode;
    t_abort;
    t_remap;
    t_prio;
    tally_and_finish;
  end
endmodule // smc_controller_bench
